// ---- tapsl_defs.vh ----
// constants for the tap and autosleep detector
`ifndef TAPSL_DEFS_VH
`define TAPSL_DEFS_VH
// register addresses
`define TAPSL_A_LEVEL   8'h1d
`define TAPSL_A_LIMIT   8'h21
`define TAPSL_A_GAP     8'h22
`define TAPSL_A_WINDOW  8'h23
`define TAPSL_A_AXES    8'h2a
`define TAPSL_A_REPORT  8'h2b
`define TAPSL_A_UNMASK  8'h2e
`define TAPSL_A_ROUTE   8'h2f
`define TAPSL_A_FLAGS   8'h30
// event bit positions (unmask, route, flags)
`define TAPSL_B_SINGLE  6
`define TAPSL_B_DOUBLE  5
`define TAPSL_B_ACT     4
`define TAPSL_B_INACT   3
`define TAPSL_B_FREE    2
// tap axis select fields
`define TAPSL_B_SUPP    3
`define TAPSL_B_AXX     2
// first axis report fields
`define TAPSL_B_ASLEEP  3
`define TAPSL_B_TAPX    2
// reset value of registers
`define TAPSL_RST8      8'h00
// tap state codes
`define TAPSL_S_IDLE    3'h0
`define TAPSL_S_TAP1    3'h1
`define TAPSL_S_GAP     3'h2
`define TAPSL_S_WIN     3'h3
`define TAPSL_S_TAP2    3'h4
`define TAPSL_S_HOLD    3'h5
`endif

// ---- tapsl_axis_cmp.v ----
// per-axis magnitude compare against the tap level
`default_nettype none
module tapsl_axis_cmp #(
  parameter W = 8
) (
  // sample and level
  input  wire signed [15:0] sample,
  input  wire [W-1:0]       level,
  input  wire               enable,
  // result
  output wire               above
);
  wire [15:0] mag;
  // magnitude of a two's complement sample
  assign mag   = sample[15] ? (~sample + 16'h0001) : sample;
  assign above = enable && (mag > {{(16-W){1'b0}}, level});
endmodule // tapsl_axis_cmp
`default_nettype wire

// ---- tapsl_detector.v ----
// tap detection, link and autosleep sequencing with its registers
`default_nettype none
`include "tapsl_defs.vh"
module tapsl_detector #(
  parameter W = 8
) (
  // clock and reset
  input  wire              sys_clk,
  input  wire              sys_rst,
  input  wire              clkEn,
  // undecimated sample stream
  input  wire              sampleTick,
  input  wire signed [15:0] accelX,
  input  wire signed [15:0] accelY,
  input  wire signed [15:0] accelZ,
  // activity, inactivity and free-fall detector inputs
  input  wire              actSeen,
  input  wire              inactSeen,
  input  wire              freeSeen,
  // mode controls
  input  wire              linkEn,
  input  wire              autoSleepEn,
  // register port
  input  wire              regWr,
  input  wire              regRd,
  input  wire [7:0]        regAddr,
  input  wire [7:0]        regWdata,
  output reg  [7:0]        regRdata,
  // outputs
  output wire              sleepRate,
  output wire              irq_line_a,
  output wire              irq_line_b
);
  // ****************************************************************
  // registers
  // ****************************************************************
  reg [7:0] levelQ, limitQ, gapQ, windowQ, axesQ, unmaskQ, routeQ;
  reg [7:0] flagsQ;
  reg [2:0] reportAxisQ;
  reg       asleepQ;
  reg       actArmQ;
  reg       inactArmQ;
  reg [2:0] stateQ;
  reg [7:0] timerQ;
  reg       singlePendQ;
  reg [2:0] firstAxisQ;

  wire [2:0] above;
  wire       anyAbove;
  wire       rdFlags;
  wire       tick;
  wire       useSingle;
  wire       useDouble;

  // ****************************************************************
  // axis compare
  // ****************************************************************
  // one comparator per axis, gated by its select bit
  tapsl_axis_cmp #(.W(W)) cmpX (
    .sample (accelX),
    .level  (levelQ),
    .enable (axesQ[`TAPSL_B_AXX]),
    .above  (above[2])
  );
  tapsl_axis_cmp #(.W(W)) cmpY (
    .sample (accelY),
    .level  (levelQ),
    .enable (axesQ[`TAPSL_B_AXX-1]),
    .above  (above[1])
  );
  tapsl_axis_cmp #(.W(W)) cmpZ (
    .sample (accelZ),
    .level  (levelQ),
    .enable (axesQ[`TAPSL_B_AXX-2]),
    .above  (above[0])
  );

  assign anyAbove  = |above;
  assign tick      = clkEn && sampleTick;
  assign rdFlags   = clkEn && regRd && (regAddr == `TAPSL_A_FLAGS);
  assign useSingle = unmaskQ[`TAPSL_B_SINGLE];
  // double needs its unmask and nonzero gap and window
  assign useDouble = unmaskQ[`TAPSL_B_DOUBLE] &&
                     (gapQ != `TAPSL_RST8) &&
                     (windowQ != `TAPSL_RST8);
  assign sleepRate = asleepQ;

  // ****************************************************************
  // tap state machine
  // ****************************************************************
  reg       evSingle;
  reg       evDouble;
  reg [2:0] stateD;
  reg [7:0] timerD;
  reg       pendD;

  // next state, timer and tap events per sample tick
  always @* begin
    stateD   = stateQ;
    timerD   = timerQ + 8'h01;
    pendD    = singlePendQ;
    evSingle = 1'b0;
    evDouble = 1'b0;
    case (stateQ)
      `TAPSL_S_IDLE: begin
        timerD = 8'h00;
        pendD  = 1'b0;
        if (anyAbove) begin
          stateD = `TAPSL_S_TAP1;
          timerD = 8'h01;
        end
      end
      `TAPSL_S_TAP1: begin
        if (!anyAbove) begin
          if (!useDouble) begin
            evSingle = 1'b1;
            stateD   = `TAPSL_S_IDLE;
          end else begin
            pendD  = 1'b1;
            stateD = `TAPSL_S_GAP;
            timerD = 8'h00;
          end
        end else if (timerQ >= limitQ) begin
          stateD = `TAPSL_S_HOLD;
        end
      end
      `TAPSL_S_GAP: begin
        if (anyAbove && axesQ[`TAPSL_B_SUPP]) begin
          evSingle = singlePendQ;
          stateD   = `TAPSL_S_HOLD;
        end else if (timerD >= gapQ) begin
          stateD = `TAPSL_S_WIN;
          timerD = 8'h00;
        end
      end
      `TAPSL_S_WIN: begin
        if (anyAbove && (timerQ == 8'h00)) begin
          evSingle = singlePendQ;
          stateD   = `TAPSL_S_HOLD;
        end else if (anyAbove) begin
          stateD = `TAPSL_S_TAP2;
          timerD = 8'h01;
        end else if (timerD >= windowQ) begin
          evSingle = singlePendQ;
          stateD   = `TAPSL_S_IDLE;
        end
      end
      `TAPSL_S_TAP2: begin
        if (!anyAbove) begin
          evSingle = singlePendQ;
          evDouble = 1'b1;
          stateD   = `TAPSL_S_IDLE;
        end else if (timerQ >= limitQ) begin
          evSingle = singlePendQ;
          stateD   = `TAPSL_S_HOLD;
        end
      end
      `TAPSL_S_HOLD: begin
        // wait for level to drop before a new tap can start
        if (!anyAbove) begin
          stateD = `TAPSL_S_IDLE;
        end
      end
      default: begin
        stateD = `TAPSL_S_IDLE;
      end
    endcase
  end

  // tap state registers, advance only on sample ticks
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      stateQ      <= `TAPSL_S_IDLE;
      timerQ      <= 8'h00;
      singlePendQ <= 1'b0;
      firstAxisQ  <= 3'h0;
    end else if (tick) begin
      stateQ      <= stateD;
      timerQ      <= timerD;
      singlePendQ <= pendD;
      if (stateQ == `TAPSL_S_IDLE && anyAbove) begin
        firstAxisQ <= above;
      end
    end
  end

  // ****************************************************************
  // link and autosleep
  // ****************************************************************
  wire actEv;
  wire inactEv;
  // without link both detectors stay armed
  assign actEv   = tick && actSeen && (actArmQ || !linkEn);
  assign inactEv = tick && inactSeen && (inactArmQ || !linkEn);

  // arming and sleep state
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      actArmQ   <= 1'b0;
      inactArmQ <= 1'b1;
      asleepQ   <= 1'b0;
    end else if (clkEn) begin
      if (linkEn && actEv) begin
        actArmQ   <= 1'b0;
        inactArmQ <= 1'b1;
        asleepQ   <= 1'b0;
      end else if (linkEn && inactEv) begin
        actArmQ   <= 1'b1;
        inactArmQ <= 1'b0;
        // uncleared activity blocks autosleep
        if (autoSleepEn && !flagsQ[`TAPSL_B_ACT]) begin
          asleepQ <= 1'b1;
        end
      end
    end
  end

  // ****************************************************************
  // event flags
  // ****************************************************************
  reg [7:0] setBits;
  // masked event set bits; a set in the read cycle survives the clear
  always @* begin
    setBits = 8'h00;
    setBits[`TAPSL_B_SINGLE] = tick && evSingle && useSingle;
    setBits[`TAPSL_B_DOUBLE] = tick && evDouble && useDouble;
    setBits[`TAPSL_B_ACT]    = actEv && unmaskQ[`TAPSL_B_ACT];
    setBits[`TAPSL_B_INACT]  = inactEv && unmaskQ[`TAPSL_B_INACT];
    setBits[`TAPSL_B_FREE]   = tick && freeSeen && unmaskQ[`TAPSL_B_FREE];
  end

  // flags clear on read, first axis report overwritten on tap event
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      flagsQ      <= `TAPSL_RST8;
      reportAxisQ <= 3'h0;
    end else if (clkEn) begin
      flagsQ <= (rdFlags ? 8'h00 : flagsQ) | setBits;
      if (setBits[`TAPSL_B_SINGLE] || setBits[`TAPSL_B_DOUBLE]) begin
        reportAxisQ <= firstAxisQ;
      end
    end
  end

  // interrupt lines follow routing, ORed per line
  assign irq_line_a = |(flagsQ & ~routeQ);
  assign irq_line_b = |(flagsQ & routeQ);

  // ****************************************************************
  // register port
  // ****************************************************************
  // writable registers
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      levelQ  <= `TAPSL_RST8;
      limitQ  <= `TAPSL_RST8;
      gapQ    <= `TAPSL_RST8;
      windowQ <= `TAPSL_RST8;
      axesQ   <= `TAPSL_RST8;
      unmaskQ <= `TAPSL_RST8;
      routeQ  <= `TAPSL_RST8;
    end else if (clkEn && regWr) begin
      case (regAddr)
        `TAPSL_A_LEVEL:  levelQ  <= regWdata;
        `TAPSL_A_LIMIT:  limitQ  <= regWdata;
        `TAPSL_A_GAP:    gapQ    <= regWdata;
        `TAPSL_A_WINDOW: windowQ <= regWdata;
        `TAPSL_A_AXES:   axesQ   <= regWdata;
        `TAPSL_A_UNMASK: unmaskQ <= regWdata;
        `TAPSL_A_ROUTE:  routeQ  <= regWdata;
        default: begin
        end
      endcase
    end
  end

  // read data registered one cycle after the read strobe
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      regRdata <= 8'h00;
    end else if (clkEn && regRd) begin
      case (regAddr)
        `TAPSL_A_LEVEL:  regRdata <= levelQ;
        `TAPSL_A_LIMIT:  regRdata <= limitQ;
        `TAPSL_A_GAP:    regRdata <= gapQ;
        `TAPSL_A_WINDOW: regRdata <= windowQ;
        `TAPSL_A_AXES:   regRdata <= axesQ;
        `TAPSL_A_REPORT: regRdata <= {4'h0, asleepQ, reportAxisQ};
        `TAPSL_A_UNMASK: regRdata <= unmaskQ;
        `TAPSL_A_ROUTE:  regRdata <= routeQ;
        `TAPSL_A_FLAGS:  regRdata <= flagsQ;
        default:         regRdata <= 8'h00;
      endcase
    end
  end
endmodule // tapsl_detector
`default_nettype wire

// ---- tapsl_props.sv ----
// checker on the tap and autosleep detector ports
`default_nettype none
`include "tapsl_defs.vh"
module tapsl_props (
  // clock, reset and inputs
  input wire logic       sys_clk,
  input wire logic       sys_rst,
  input wire logic       clkEn,
  input wire logic       sampleTick,
  input wire logic       actSeen,
  input wire logic       inactSeen,
  input wire logic       linkEn,
  input wire logic       autoSleepEn,
  input wire logic       regRd,
  input wire logic [7:0] regAddr,
  // outputs
  input wire logic [7:0] regRdata,
  input wire logic       sleepRate,
  input wire logic       irq_line_a,
  input wire logic       irq_line_b
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // properties
  // ****
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // reads taken with no sample in flight, so no new event can land
  sequence rdFlags;
    clkEn && regRd && !sampleTick && regAddr == `TAPSL_A_FLAGS;
  endsequence
  sequence rdReport;
    clkEn && regRd && !sampleTick && regAddr == `TAPSL_A_REPORT;
  endsequence
  a_flags_read_clear: assert property (
    rdFlags ##1 !sampleTick ##1 rdFlags |=> regRdata == 8'h00)
    else $error("flags not cleared by read");
  a_irq_read_drop: assert property (
    rdFlags |=> !irq_line_a && !irq_line_b)
    else $error("irq lines kept after flag read");
  a_report_kept: assert property (
    rdReport ##1 !sampleTick ##1 rdReport |=> regRdata == $past(regRdata, 2))
    else $error("axis report changed without event");
  a_asleep_bit: assert property (
    rdReport |=> regRdata[`TAPSL_B_ASLEEP] == $past(sleepRate))
    else $error("asleep bit differs from sleep state");
  a_sleep_cause: assert property (
    $rose(sleepRate) |-> $past(linkEn && autoSleepEn && inactSeen))
    else $error("sleep entered without inactivity");
  a_wake_on_act: assert property (
    sleepRate && clkEn && sampleTick && actSeen |-> ##[1:2] !sleepRate)
    else $error("no wake on activity");
  a_no_sleep_unlinked: assert property (
    !linkEn && !sleepRate |=> !sleepRate)
    else $error("sleep without link");
  a_rdata_holds: assert property (
    clkEn && !regRd |=> $stable(regRdata))
    else $error("read data moved without read");
  a_reset_quiet: assert property (
    $fell(sys_rst) |-> !irq_line_a && !irq_line_b && !sleepRate)
    else $error("outputs active after reset");
endmodule // tapsl_props
`default_nettype wire

// ---- tapsl_host.sv ----
// host processor model on the register port
`default_nettype none
module tapsl_host (
  // clock
  input  wire logic       sys_clk,
  // register port
  output var  logic       regWr,
  output var  logic       regRd,
  output var  logic [7:0] regAddr,
  output var  logic [7:0] regWdata,
  input  wire logic [7:0] regRdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle port from time zero
  initial begin
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 8'h00;
    regWdata = 8'h00;
  end
  // one byte write, strobe up for exactly one edge
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    regAddr = a;
    regWdata = d;
    regWr = 1'b1;
    @(negedge sys_clk);
    regWr = 1'b0;
  endtask
  // one byte read; data is registered, so taken a cycle later
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    regAddr = a;
    regRd = 1'b1;
    @(negedge sys_clk);
    regRd = 1'b0;
    d = regRdata;
  endtask
endmodule // tapsl_host
`default_nettype wire

// ---- tb_tap_and_autosleep_detector.sv ----
// self-checking bench for the tap and autosleep detector
`default_nettype none
`include "tapsl_defs.vh"
module tb_tap_and_autosleep_detector;
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // stimulus and design
  // ****
  logic        sys_clk = 1'b0, sys_rst = 1'b1, sampleTick = 1'b0;
  logic        actSeen = 1'b0, inactSeen = 1'b0, freeSeen = 1'b0;
  logic        linkEn = 1'b0, autoSleepEn = 1'b0, clkEn = 1'b1;
  logic [15:0] accelX = 16'h0000, accelY = 16'h0000, accelZ = 16'h0000;
  logic [7:0]  v;
  wire         regWr, regRd, sleepRate, irq_line_a, irq_line_b;
  wire  [7:0]  regAddr, regWdata, regRdata;
  int          n_fail = 0, n_tests = 0;
  // 20 MHz clock
  initial forever #25 sys_clk = ~sys_clk;
  tapsl_host h (.sys_clk(sys_clk), .regWr(regWr), .regRd(regRd),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata));
  tapsl_detector dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .clkEn(clkEn),
    .sampleTick(sampleTick), .accelX(accelX), .accelY(accelY),
    .accelZ(accelZ), .actSeen(actSeen), .inactSeen(inactSeen),
    .freeSeen(freeSeen), .linkEn(linkEn), .autoSleepEn(autoSleepEn),
    .regWr(regWr), .regRd(regRd), .regAddr(regAddr), .regWdata(regWdata),
    .regRdata(regRdata), .sleepRate(sleepRate), .irq_line_a(irq_line_a),
    .irq_line_b(irq_line_b));
  // ****
  // tasks
  // ****
  task close_out;
    $display("checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h, want %h", $time, got, exp);
    end
  endtask
  task rdchk(input logic [7:0] a, input logic [7:0] exp);
    h.rd(a, v);
    chk(v, exp);
  endtask
  // n sample ticks of one value; ticks pause after, so timers pause too
  task drive(input logic [15:0] x, input logic [15:0] y, input int n);
    repeat (n) begin
      @(negedge sys_clk);
      sampleTick = 1'b1;
      accelX = x;
      accelY = y;
    end
    @(negedge sys_clk);
    sampleTick = 1'b0;
  endtask
  // two taps on x: 2 ticks, lo quiet ticks, hi ticks, then settle
  task tap2(input int lo, input int hi, input logic [7:0] exp);
    drive(16'h0100, 16'h0000, 2);
    drive(16'h0000, 16'h0000, lo);
    drive(16'h0100, 16'h0000, hi);
    drive(16'h0000, 16'h0000, 20);
    // single sits on line a, double on line b once routed there
    chk({6'h00, irq_line_b, irq_line_a}, {6'h00, exp[5], exp[6]});
    rdchk(`TAPSL_A_FLAGS, exp);
  endtask
  // a hang counts as a mismatch
  initial begin
    #2000000;
    n_fail++;
    close_out;
  end
  // ****
  // scenarios
  // ****
  initial begin
    repeat (10) @(negedge sys_clk);
    sys_rst = 1'b0;
    h.wr(`TAPSL_A_LEVEL, 8'h31);
    rdchk(`TAPSL_A_LEVEL, 8'h31);
    // clock enable low freezes the port, so this write is lost
    clkEn = 1'b0;
    h.wr(`TAPSL_A_LEVEL, 8'h55);
    clkEn = 1'b1;
    rdchk(`TAPSL_A_LEVEL, 8'h31);
    rdchk(8'h3a, 8'h00);
    h.wr(`TAPSL_A_REPORT, 8'hff);
    rdchk(`TAPSL_A_REPORT, 8'h00);
    h.wr(`TAPSL_A_LIMIT, 8'h04);
    h.wr(`TAPSL_A_AXES, 8'h04);
    h.wr(`TAPSL_A_UNMASK, 8'h40);
    // negative x tap, within the length limit
    drive(16'hff00, 16'h0000, 2);
    drive(16'h0000, 16'h0000, 3);
    chk({7'h00, irq_line_a}, 8'h01);
    rdchk(`TAPSL_A_FLAGS, 8'h40);
    chk({7'h00, irq_line_a}, 8'h00);
    rdchk(`TAPSL_A_FLAGS, 8'h00);
    rdchk(`TAPSL_A_REPORT, 8'h04);
    rdchk(`TAPSL_A_REPORT, 8'h04);
    drive(16'h0100, 16'h0000, 6);
    drive(16'h0000, 16'h0000, 3);
    rdchk(`TAPSL_A_FLAGS, 8'h00);
    // y and z both tap, but neither is selected
    accelZ = 16'h0100;
    drive(16'h0000, 16'h0100, 2);
    accelZ = 16'h0000;
    drive(16'h0000, 16'h0000, 3);
    rdchk(`TAPSL_A_FLAGS, 8'h00);
    // double tap needs both timing values, and its mask bit
    h.wr(`TAPSL_A_GAP, 8'h03);
    h.wr(`TAPSL_A_UNMASK, 8'h60);
    tap2(5, 2, 8'h40);
    h.wr(`TAPSL_A_WINDOW, 8'h08);
    h.wr(`TAPSL_A_UNMASK, 8'h40);
    tap2(5, 2, 8'h40);
    h.wr(`TAPSL_A_UNMASK, 8'h60);
    h.wr(8'h2f, 8'h20);
    drive(16'h0100, 16'h0000, 2);
    drive(16'h0000, 16'h0000, 1);
    chk({7'h00, irq_line_a}, 8'h00);
    tap2(4, 2, 8'h60);
    tap2(5, 6, 8'h40);
    tap2(1, 6, 8'h40);
    h.wr(`TAPSL_A_AXES, 8'h0c);
    // spike in the gap; without suppress the later tap would be a double
    drive(16'h0100, 16'h0000, 2);
    drive(16'h0000, 16'h0000, 1);
    tap2(3, 2, 8'h40);
    // linked autosleep: inactivity sleeps, activity wakes
    h.wr(`TAPSL_A_UNMASK, 8'h78);
    linkEn = 1'b1;
    autoSleepEn = 1'b1;
    inactSeen = 1'b1;
    drive(16'h0000, 16'h0000, 3);
    inactSeen = 1'b0;
    chk({7'h00, sleepRate}, 8'h01);
    rdchk(`TAPSL_A_REPORT, 8'h0c);
    actSeen = 1'b1;
    drive(16'h0000, 16'h0000, 3);
    actSeen = 1'b0;
    chk({7'h00, sleepRate}, 8'h00);
    inactSeen = 1'b1;
    drive(16'h0000, 16'h0000, 3);
    inactSeen = 1'b0;
    chk({7'h00, sleepRate}, 8'h00);
    rdchk(`TAPSL_A_FLAGS, 8'h18);
    // free-fall flag on line a, cleared by the flag read
    h.wr(`TAPSL_A_UNMASK, 8'h04);
    freeSeen = 1'b1;
    drive(16'h0000, 16'h0000, 1);
    freeSeen = 1'b0;
    chk({7'h00, irq_line_a}, 8'h01);
    rdchk(`TAPSL_A_FLAGS, 8'h04);
    chk({7'h00, irq_line_a}, 8'h00);
    close_out;
  end
endmodule // tb_tap_and_autosleep_detector
bind tapsl_detector tapsl_props props (.sys_clk, .sys_rst, .clkEn,
  .sampleTick, .actSeen, .inactSeen, .linkEn, .autoSleepEn, .regRd,
  .regAddr, .regRdata, .sleepRate, .irq_line_a, .irq_line_b);
`default_nettype wire
